//--- xfer_act_pkg.sv
// Package for the SD host transfer activity status block.
// Assumes an AHB-Lite register bus with 32-bit data and word accesses.
package xfer_act_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PRESENT      = 8'h00;
  localparam logic [7:0] OFS_BLOCK_GAP    = 8'h04;
  localparam logic [7:0] OFS_NIRQ_STATUS  = 8'h08;
  localparam logic [7:0] OFS_NIRQ_STS_EN  = 8'h0C;
  localparam logic [7:0] OFS_NIRQ_SIG_EN  = 8'h10;
  localparam logic [7:0] OFS_RETUNE_STS   = 8'h14;
  localparam logic [7:0] OFS_RETUNE_STSEN = 8'h18;
  localparam logic [7:0] OFS_XFER_COUNT   = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int BIT_DAT_ACTIVE   = 0;
  localparam int BIT_WR_ACTIVE    = 1;
  localparam int BIT_RD_ACTIVE    = 2;
  localparam int BIT_READ_WAIT    = 3;
  localparam int BIT_STOP_GAP     = 0;
  localparam int BIT_CONTINUE     = 1;
  localparam int BIT_XFER_DONE    = 0;
  localparam int BIT_BLOCK_GAP    = 1;
  localparam int BIT_RETUNE_EVT   = 0;

  // ==========================================================
  // Reset values and timing
  localparam logic [1:0]  NIRQ_RESET     = 2'h0;
  localparam logic [7:0]  RETUNE_EN_RST  = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam int          BUSY_WAIT_SDCLK = 8;
  localparam logic [3:0]  BUSY_WAIT_CNT  = 4'(BUSY_WAIT_SDCLK);

  // Activity machine states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WRITE   = 3'b001,
    ST_WR_BUSY = 3'b010,
    ST_READ    = 3'b011,
    ST_RD_HALT = 3'b100,
    ST_CMD_BSY = 3'b101,
    ST_WR_GAP  = 3'b110
  } act_state_t;

  // Card-side event strobes from the data path
  typedef struct packed {
    logic wr_cmd_end;
    logic rd_cmd_end;
    logic busy_cmd_end;
    logic crc_status;
    logic block_to_sys;
    logic adma_end;
    logic buf_full;
  } card_evt_t;

endpackage : xfer_act_pkg

//--- xfer_act.sv
// SD host data-line activity tracker with AHB-Lite register slave.
// Assumes card events arrive as one-cycle strobes on hclk; sdclk_tick is a
// one-cycle enable per card clock; card_busy is a raw pin level.
`timescale 1ns/1ps
`default_nettype none

module xfer_act
  import xfer_act_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire card_evt_t   card_evt,
  input  wire logic        card_busy,
  input  wire logic        sdclk_tick,
  input  wire logic        retune_timer_event,
  output logic             read_wait_oe,
  output logic             read_wait_out,
  output logic             sdclk_stop,
  output logic             irq
);

  // ==========================================================
  // Bus address phase capture
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;
  wire        addr_take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= addr_take & hwrite;
      rd_pend_reg <= addr_take & ~hwrite;
      if (addr_take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  wire wr_block_gap = wr_pend_reg & (addr_reg == OFS_BLOCK_GAP);
  wire wr_nsts_en   = wr_pend_reg & (addr_reg == OFS_NIRQ_STS_EN);
  wire wr_nsig_en   = wr_pend_reg & (addr_reg == OFS_NIRQ_SIG_EN);
  wire wr_rt_en     = wr_pend_reg & (addr_reg == OFS_RETUNE_STSEN);
  wire wr_count     = wr_pend_reg & (addr_reg == OFS_XFER_COUNT);
  wire rd_nsts      = rd_pend_reg & (addr_reg == OFS_NIRQ_STATUS);
  wire rd_rtsts     = rd_pend_reg & (addr_reg == OFS_RETUNE_STS);
  wire cont_req     = wr_block_gap & hwdata[BIT_CONTINUE];

  // ==========================================================
  // Busy pin synchroniser
  logic busy_s1_reg;
  logic busy_s2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end else begin
      busy_s1_reg <= card_busy;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  // ==========================================================
  // Control registers
  logic        stop_at_gap_request;
  logic [1:0]  nsts_en_reg;
  logic [1:0]  nsig_en_reg;
  logic [7:0]  retune_irq_status_enable;
  logic [15:0] count_reg;
  logic [15:0] left_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_at_gap_request      <= 1'b0;
      nsts_en_reg              <= NIRQ_RESET;
      nsig_en_reg              <= NIRQ_RESET;
      retune_irq_status_enable <= RETUNE_EN_RST;
      count_reg                <= COUNT_RESET;
    end else begin
      if (wr_block_gap) begin
        stop_at_gap_request <= hwdata[BIT_STOP_GAP];
      end
      if (wr_nsts_en) begin
        nsts_en_reg <= hwdata[1:0];
      end
      if (wr_nsig_en) begin
        nsig_en_reg <= hwdata[1:0];
      end
      if (wr_rt_en) begin
        retune_irq_status_enable <= hwdata[7:0];
      end
      if (wr_count) begin
        count_reg <= hwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Activity state machine
  act_state_t state_reg;
  act_state_t state_next;
  logic [3:0] wait_reg;
  logic       busy_seen_reg;

  wire last_blk  = (left_reg <= 16'h0001) | card_evt.adma_end;
  wire busy_rel  = busy_seen_reg & ~busy_s2_reg;
  wire no_busy   = ~busy_seen_reg & (wait_reg == 4'h0);
  wire busy_done = busy_rel | no_busy;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (card_evt.wr_cmd_end) begin
          state_next = ST_WRITE;
        end else if (card_evt.rd_cmd_end) begin
          state_next = ST_READ;
        end else if (card_evt.busy_cmd_end) begin
          state_next = ST_CMD_BSY;
        end
      end
      ST_WRITE: begin
        if (card_evt.crc_status & (last_blk | stop_at_gap_request)) begin
          state_next = ST_WR_BUSY;
        end
      end
      ST_WR_BUSY: begin
        if (busy_done) begin
          state_next = stop_at_gap_request ? ST_WR_GAP : ST_IDLE;
        end
      end
      ST_WR_GAP: begin
        if (cont_req) begin
          state_next = ST_WRITE;
        end
      end
      ST_READ: begin
        if (card_evt.block_to_sys & last_blk) begin
          state_next = ST_IDLE;
        end else if (card_evt.block_to_sys & stop_at_gap_request) begin
          state_next = ST_RD_HALT;
        end
      end
      ST_RD_HALT: begin
        if (cont_req) begin
          state_next = ST_READ;
        end
      end
      ST_CMD_BSY: begin
        if (busy_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire enter_busy = (state_next == ST_WR_BUSY && state_reg != ST_WR_BUSY) ||
                    (state_next == ST_CMD_BSY && state_reg != ST_CMD_BSY);
  wire blk_done = (state_reg == ST_WRITE & card_evt.crc_status) |
                  (state_reg == ST_READ & card_evt.block_to_sys);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= ST_IDLE;
      wait_reg      <= 4'h0;
      busy_seen_reg <= 1'b0;
      left_reg      <= COUNT_RESET;
    end else begin
      state_reg <= state_next;
      if (enter_busy) begin
        wait_reg      <= BUSY_WAIT_CNT;
        busy_seen_reg <= 1'b0;
      end else begin
        if (sdclk_tick && wait_reg != 4'h0) begin
          wait_reg <= wait_reg - 4'h1;
        end
        if (busy_s2_reg) begin
          busy_seen_reg <= 1'b1;
        end
      end
      if (state_reg == ST_IDLE) begin
        left_reg <= count_reg;
      end else if (blk_done && left_reg != 16'h0000) begin
        left_reg <= left_reg - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Activity bits, edges and status flags
  logic dat_active;
  logic write_transfer_active;
  logic read_transfer_active;
  logic buf_full_hold_reg;

  wire dat_next = (state_next == ST_WRITE) | (state_next == ST_WR_BUSY) |
                  (state_next == ST_READ) | (state_next == ST_CMD_BSY) |
                  (state_next == ST_RD_HALT);
  wire wr_next  = (state_next == ST_WRITE);
  wire rd_next  = (state_next == ST_READ) | (state_next == ST_RD_HALT);
  wire dat_fall = dat_active & ~dat_next;
  wire gap_fall = write_transfer_active & ~wr_next & stop_at_gap_request;

  wire xfer_set = dat_fall & nsts_en_reg[BIT_XFER_DONE];
  wire gap_set  = gap_fall & nsts_en_reg[BIT_BLOCK_GAP];
  wire rt_set   = retune_timer_event &
                  retune_irq_status_enable[BIT_RETUNE_EVT];

  logic [1:0] transfer_flags;
  logic       retune_irq_status;

  // A read clears only the bits it returned, so a set at its address edge
  // is kept; a set in the clearing cycle wins as well
  wire [1:0] nsts_clr   = {2{rd_nsts}} & hrdata[1:0];
  wire       rt_clr     = rd_rtsts & hrdata[BIT_RETUNE_EVT];
  wire [1:0] flags_next = {gap_set, xfer_set} | (transfer_flags & ~nsts_clr);
  wire       rt_next    = rt_set | (retune_irq_status & ~rt_clr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dat_active            <= 1'b0;
      write_transfer_active <= 1'b0;
      read_transfer_active  <= 1'b0;
      transfer_flags        <= NIRQ_RESET;
      retune_irq_status     <= 1'b0;
    end else begin
      dat_active            <= dat_next;
      write_transfer_active <= wr_next;
      read_transfer_active  <= rd_next;
      transfer_flags        <= flags_next;
      retune_irq_status     <= rt_next;
    end
  end

  wire transfer_complete_flag = transfer_flags[BIT_XFER_DONE];
  wire block_gap_event_flag   = transfer_flags[BIT_BLOCK_GAP];

  // ==========================================================
  // Read Wait during a halted read or a full buffer, clock stop during a halted read
  wire halt_next = (state_next == ST_RD_HALT);
  wire rw_next   = halt_next | (rd_next & card_evt.buf_full) |
                   (buf_full_hold_reg & rd_next);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_wait_oe      <= 1'b0;
      read_wait_out     <= 1'b0;
      sdclk_stop        <= 1'b0;
      buf_full_hold_reg <= 1'b0;
      irq               <= 1'b0;
    end else begin
      buf_full_hold_reg <= rd_next & (card_evt.buf_full |
                           (buf_full_hold_reg & halt_next));
      read_wait_oe      <= rw_next;
      read_wait_out     <= 1'b0;
      sdclk_stop        <= halt_next;
      irq <= (|(flags_next & nsig_en_reg)) | rt_next;
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] rdata_mux;
  always_comb begin
    rdata_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_PRESENT: begin
        rdata_mux[BIT_DAT_ACTIVE] = dat_active;
        rdata_mux[BIT_WR_ACTIVE]  = write_transfer_active;
        rdata_mux[BIT_RD_ACTIVE]  = read_transfer_active;
        rdata_mux[BIT_READ_WAIT]  = read_wait_oe;
      end
      OFS_BLOCK_GAP:    rdata_mux[BIT_STOP_GAP] = stop_at_gap_request;
      OFS_NIRQ_STATUS:  rdata_mux[1:0] = transfer_flags;
      OFS_NIRQ_STS_EN:  rdata_mux[1:0] = nsts_en_reg;
      OFS_NIRQ_SIG_EN:  rdata_mux[1:0] = nsig_en_reg;
      OFS_RETUNE_STS:   rdata_mux[BIT_RETUNE_EVT] = retune_irq_status;
      OFS_RETUNE_STSEN: rdata_mux[7:0] = retune_irq_status_enable;
      OFS_XFER_COUNT:   rdata_mux[15:0] = count_reg;
      default:          rdata_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take & ~hwrite) begin
      hrdata <= rdata_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  chk_dat_fall_flag: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $fell(dat_active) && $past(nsts_en_reg[BIT_XFER_DONE]) |->
    transfer_complete_flag) else $error("transfer complete not set");
  chk_wr_sets_dat: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_IDLE && card_evt.wr_cmd_end |=>
    dat_active && write_transfer_active) else $error("write not active");
  chk_busy_timeout: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg inside {ST_CMD_BSY, ST_WR_BUSY} && wait_reg == 4'h0 &&
    !busy_seen_reg |=> !dat_active) else $error("busy timeout missed");
  chk_wr_crc_last: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_WRITE && card_evt.crc_status && last_blk |=>
    !write_transfer_active) else $error("write active stuck");
  chk_gap_event: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $fell(write_transfer_active) && $past(stop_at_gap_request) &&
    $past(nsts_en_reg[BIT_BLOCK_GAP]) |-> block_gap_event_flag)
    else $error("gap event lost");
  chk_rd_sets: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_IDLE && card_evt.rd_cmd_end && !card_evt.wr_cmd_end |=>
    read_transfer_active) else $error("read not active");
  chk_halt_wait: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_RD_HALT |-> read_wait_oe && sdclk_stop)
    else $error("halt not driven");
  chk_retune_mask: assert property (@(posedge hclk)
    disable iff (!hresetn)
    !$past(retune_irq_status_enable[BIT_RETUNE_EVT]) &&
    !$past(retune_irq_status) |-> !retune_irq_status)
    else $error("retune not masked");
  chk_busy_cmd: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_IDLE && card_evt.busy_cmd_end &&
    !card_evt.wr_cmd_end && !card_evt.rd_cmd_end |=>
    dat_active && !write_transfer_active && !read_transfer_active)
    else $error("busy command not active");
  chk_wr_continue: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_WR_GAP && cont_req |=>
    dat_active && write_transfer_active) else $error("write not resumed");
  chk_rd_last: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_reg == ST_READ && card_evt.block_to_sys && last_blk |=>
    !read_transfer_active) else $error("read active stuck");
  cov_write_done: cover property (@(posedge hclk) $fell(write_transfer_active));
  cov_read_halt:  cover property (@(posedge hclk) state_reg == ST_RD_HALT);
  cov_cmd_busy:   cover property (@(posedge hclk) state_reg == ST_CMD_BSY);

endmodule : xfer_act

`default_nettype wire

//--- card_model.sv
// Card-side model: command end bits, CRC status, block and busy events.
// Assumes the bench calls its tasks right after a rising edge of hclk.
`timescale 1ns/1ps
`default_nettype none

module card_model
  import xfer_act_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  output card_evt_t card_evt,
  output logic      card_busy,
  output logic      sdclk_tick
);
  logic [1:0] div_reg;
  logic [6:0] ev_reg;
  logic       full_reg;

  initial begin
    ev_reg    = 7'h00;
    full_reg  = 1'b0;
    card_busy = 1'b0;
  end

  // ==========================================================
  // Card clock enable, one hclk cycle in four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_reg <= 2'h0;
    else          div_reg <= div_reg + 2'h1;
  end
  assign sdclk_tick = (div_reg == 2'h3);
  assign card_evt   = card_evt_t'({ev_reg[6:1], full_reg});

  // ==========================================================
  // Event strobes last exactly one cycle
  task automatic strobe(input logic [6:0] m);
    ev_reg <= m;
    @(posedge hclk);
    ev_reg <= 7'h00;
    @(posedge hclk);
  endtask : strobe

  // Busy held for n card clocks; a released line reads not busy
  task automatic busy(input int n);
    card_busy <= 1'b1;
    repeat (n * 4) @(posedge hclk);
    card_busy <= 1'b0;
    @(posedge hclk);
  endtask : busy

  task automatic full(input logic v);
    full_reg <= v;
    @(posedge hclk);
  endtask : full
endmodule : card_model

`default_nettype wire

//--- tb.sv
// Self-checking bench for the transfer activity tracker.
// Assumes a zero-wait AHB-Lite slave and the card model beside it.
`timescale 1ns/1ps
`default_nettype none

module tb
  import xfer_act_pkg::*;
;
  localparam logic [6:0] E_WR  = 7'h40;
  localparam logic [6:0] E_RD  = 7'h20;
  localparam logic [6:0] E_BSY = 7'h10;
  localparam logic [6:0] E_CRC = 7'h08;
  localparam logic [6:0] E_BLK = 7'h04;
  localparam logic [6:0] E_ADM = 7'h02;
  localparam int         P_IRQ   = 0;
  localparam int         P_RWOE  = 1;
  localparam int         P_STOP  = 2;
  localparam int         P_RWOUT = 3;

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        card_busy, sdclk_tick, retune_timer_event, irq;
  logic        read_wait_oe, read_wait_out, sdclk_stop;
  card_evt_t   card_evt;
  int          miscompares, n_checks, cycles;
  wire [3:0]   pv = {read_wait_out, sdclk_stop, read_wait_oe, irq};

  assign hready = hreadyout;

  xfer_act i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .card_evt, .card_busy,
    .sdclk_tick, .retune_timer_event, .read_wait_oe, .read_wait_out,
    .sdclk_stop, .irq);

  card_model i_card (.hclk, .hresetn, .card_evt, .card_busy, .sdclk_tick);

  // ==========================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc

  task automatic wait_c(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_c

  // Pin level looked at mid-cycle, then back on the rising edge
  task automatic pin(input int s, input logic e);
    @(negedge hclk);
    chk({31'h0, pv[s]}, {31'h0, e});
    @(posedge hclk);
  endtask : pin

  task automatic tick_retune;
    retune_timer_event <= 1'b1;
    @(posedge hclk);
    retune_timer_event <= 1'b0;
    @(posedge hclk);
  endtask : tick_retune

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Test sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    retune_timer_event = 1'b0;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(OFS_PRESENT, 32'h0);
    rdc(OFS_NIRQ_STATUS, 32'h0);
    rdc(OFS_RETUNE_STSEN, {24'h0, RETUNE_EN_RST});
    rdc(8'h20, 32'h0);
    wr(OFS_NIRQ_STS_EN, 32'h3);
    wr(OFS_NIRQ_SIG_EN, 32'h1);
    wr(OFS_XFER_COUNT, 32'h1);
    rdc(OFS_NIRQ_STS_EN, 32'h3);
    // Single block write, card busy after CRC status
    i_card.strobe(E_WR);
    rdc(OFS_PRESENT, 32'h3);
    i_card.strobe(E_CRC);
    rdc(OFS_PRESENT, 32'h1);
    i_card.busy(3);
    wait_c(6);
    rdc(OFS_PRESENT, 32'h0);
    pin(P_IRQ, 1'b1);
    rdc(OFS_NIRQ_STATUS, 32'h1);
    rdc(OFS_NIRQ_STATUS, 32'h0);
    pin(P_IRQ, 1'b0);
    // Write where the card never signals busy
    i_card.strobe(E_WR);
    i_card.strobe(E_CRC);
    wait_c(6);
    rdc(OFS_PRESENT, 32'h1);
    wait_c(40);
    rdc(OFS_PRESENT, 32'h0);
    rdc(OFS_NIRQ_STATUS, 32'h1);
    // Write stopped at the block gap, then continued
    wr(OFS_XFER_COUNT, 32'h2);
    wr(OFS_BLOCK_GAP, 32'h1);
    i_card.strobe(E_WR);
    i_card.strobe(E_CRC);
    rdc(OFS_PRESENT, 32'h1);
    i_card.busy(2);
    wait_c(6);
    rdc(OFS_PRESENT, 32'h0);
    rdc(OFS_NIRQ_STATUS, 32'h3);
    chk(q & 32'h2, 32'h2);
    wr(OFS_BLOCK_GAP, 32'h2);
    wait_c(2);
    rdc(OFS_PRESENT, 32'h3);
    i_card.strobe(E_CRC);
    rdc(OFS_PRESENT, 32'h1);
    wait_c(45);
    rdc(OFS_PRESENT, 32'h0);
    rdc(OFS_NIRQ_STATUS, 32'h1);
    // Command with busy
    i_card.strobe(E_BSY);
    rdc(OFS_PRESENT, 32'h1);
    i_card.busy(2);
    wait_c(6);
    rdc(OFS_PRESENT, 32'h0);
    rdc(OFS_NIRQ_STATUS, 32'h1);
    // Two block read
    i_card.strobe(E_RD);
    rdc(OFS_PRESENT, 32'h5);
    i_card.strobe(E_BLK);
    rdc(OFS_PRESENT, 32'h5);
    i_card.strobe(E_BLK);
    rdc(OFS_PRESENT, 32'h0);
    rdc(OFS_NIRQ_STATUS, 32'h1);
    // Read halted at the gap with the buffer full, then resumed
    wr(OFS_BLOCK_GAP, 32'h1);
    i_card.full(1'b1);
    i_card.strobe(E_RD);
    i_card.strobe(E_BLK);
    wait_c(2);
    rdc(OFS_PRESENT, 32'hD);
    chk(q & 32'h9, 32'h9);
    pin(P_RWOE, 1'b1);
    pin(P_STOP, 1'b1);
    pin(P_RWOUT, 1'b0);
    i_card.full(1'b0);
    wait_c(3);
    pin(P_RWOE, 1'b1);
    wr(OFS_BLOCK_GAP, 32'h2);
    wait_c(2);
    rdc(OFS_PRESENT, 32'h5);
    pin(P_STOP, 1'b0);
    i_card.strobe(E_ADM | E_BLK);
    rdc(OFS_PRESENT, 32'h0);
    // Retune event masked, then recorded
    wr(OFS_RETUNE_STSEN, 32'h0);
    tick_retune();
    rdc(OFS_RETUNE_STS, 32'h0);
    wr(OFS_RETUNE_STSEN, 32'h1);
    rdc(OFS_RETUNE_STSEN, 32'h1);
    tick_retune();
    rdc(OFS_RETUNE_STS, 32'h1);
    rdc(OFS_RETUNE_STS, 32'h0);
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
